// ===== logic/esp_pkg.sv
package esp_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] ESP_OFS_FMT = 8'h00;
  localparam logic [7:0] ESP_OFS_FREE_REV = 8'h04;
  localparam logic [7:0] ESP_OFS_FREE_POS = 8'h08;
  localparam logic [7:0] ESP_OFS_IDX_REV = 8'h0C;
  localparam logic [7:0] ESP_OFS_IDX_POS = 8'h10;
  localparam logic [7:0] ESP_OFS_SNAP_REV = 8'h14;
  localparam logic [7:0] ESP_OFS_SNAP_POS = 8'h18;
  localparam logic [7:0] ESP_OFS_SNAP_FLAG = 8'h1C;
  localparam logic [7:0] ESP_OFS_VALID = 8'h20;
  localparam logic [7:0] ESP_OFS_HOLD = 8'h24;
  localparam logic [7:0] ESP_OFS_FAULT = 8'h28;
  localparam logic [7:0] ESP_OFS_LINES = 8'h2C;
  localparam logic [7:0] ESP_OFS_RATIO = 8'h30;
  localparam logic [7:0] ESP_OFS_MAIN_REV = 8'h34;
  localparam logic [7:0] ESP_OFS_MAIN_POS = 8'h38;
  // Values after reset
  localparam logic [2:0] ESP_FMT_RST = 3'h0;
  localparam logic [15:0] ESP_LINES_RST = 16'h0400;
  localparam logic [2:0] ESP_RATIO_RST = 3'h3;
  // Limits and codes
  localparam logic [2:0] ESP_RATIO_MAX = 3'h5;
  localparam logic [3:0] ESP_LG_MIN = 4'h1;
  localparam logic [3:0] ESP_LG_MAX = 4'hE;
  localparam logic [7:0] ESP_FAULT_NONE = 8'h00;
  localparam logic [7:0] ESP_FAULT_HOT = 8'h4A;
  localparam logic [1:0] ESP_PH_AB_HIGH = 2'h2;
  localparam logic [1:0] ESP_PH_F_HIGH = 2'h1;
  // Timing
  localparam int ESP_CLK_MHZ = 100;
  localparam int ESP_SVC_MS = 4;
  localparam int ESP_FAN_S = 10;
  localparam int ESP_SVC_CYC = ESP_SVC_MS * 1000 * ESP_CLK_MHZ;
  localparam int ESP_FAN_CYC = ESP_FAN_S * 1000000 * ESP_CLK_MHZ;
  localparam int ESP_N_DUMB = 1;
  // Output formats; codes 5 to 7 behave as 4
  typedef enum logic [2:0] {
    ESP_QUADRATURE_FORMAT = 3'h0,
    ESP_PULSE_DIRECTION_FORMAT = 3'h1,
    ESP_UP_DOWN_PULSE_FORMAT = 3'h2,
    ESP_QUADRATURE_LOCK = 3'h3,
    ESP_PULSE_DIRECTION_LOCK = 3'h4
  } esp_fmt_t;
endpackage

// ===== logic/esp_sim_if.sv
`timescale 1ns/100ps
interface esp_sim_if;
  logic step;
  logic dir;
  logic marker;
  logic [2:0] fmt;
  modport src (output step, output dir, output marker, output fmt);
  modport sim (input step, input dir, input marker, input fmt);
endinterface

// ===== logic/esp_sync.sv
`timescale 1ns/100ps
module esp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Pins in, synchronised out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } esp_sync_t;
  esp_sync_t q, d;

  // First stage feeds only the second
  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule

// ===== logic/esp_sim_out.sv
`timescale 1ns/100ps
module esp_sim_out (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Steps from the position logic
  esp_sim_if.sim sif,
  // Simulated encoder pins
  output logic out_a,
  output logic out_b,
  output logic out_z
);
  typedef struct packed {
    logic [1:0] ph;
    logic a;
    logic b;
    logic z;
    logic mk_prev;
    logic locked;
  } esp_sim_t;
  esp_sim_t q, d;
  logic lock_mode;
  logic pdir;
  logic mk_rise;

  // Format decode
  assign lock_mode = sif.fmt >= esp_pkg::ESP_QUADRATURE_LOCK;
  assign pdir = (sif.fmt == esp_pkg::ESP_PULSE_DIRECTION_FORMAT) ||
                (sif.fmt >= esp_pkg::ESP_PULSE_DIRECTION_LOCK);
  assign mk_rise = sif.marker && !q.mk_prev;

  // Phase walk, lock and pin encoding
  always_comb begin
    d = q;
    d.mk_prev = sif.marker;
    d.z = sif.marker;
    if (sif.step) begin
      d.ph = sif.dir ? q.ph + 2'h1 : q.ph - 2'h1;
    end
    // Unlocked formats leave marker phase free
    if (!lock_mode) begin
      d.locked = 1'b0;
    end else if (mk_rise && !q.locked) begin
      d.ph = pdir ? esp_pkg::ESP_PH_F_HIGH : esp_pkg::ESP_PH_AB_HIGH;
      d.locked = 1'b1;
    end
    if (sif.fmt == esp_pkg::ESP_UP_DOWN_PULSE_FORMAT) begin
      d.a = sif.step && sif.dir;
      d.b = sif.step && !sif.dir;
    end else if (pdir) begin
      d.a = d.ph[0];
      d.b = sif.step ? sif.dir : q.b;
    end else begin
      d.a = d.ph[1];
      d.b = d.ph[1] ^ d.ph[0];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign out_a = q.a;
  assign out_b = q.b;
  assign out_z = q.z;

  a_quad_lock_align: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && mk_rise && !q.locked && sif.fmt == esp_pkg::ESP_QUADRATURE_LOCK
    |=> out_a && out_b)
    else $error("quadrature lock not aligned");
  a_fd_lock_align: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce && mk_rise && !q.locked && lock_mode && pdir
    |=> out_a)
    else $error("pulse lock not aligned");
  a_marker_passes: assert property (@(posedge clk_sys) disable iff (!resetn)
    ce |=> out_z == $past(sif.marker))
    else $error("marker output not a copy of source");
endmodule

// ===== logic/esp_top.sv
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module esp_top #(
  parameter int SVC_CYC = esp_pkg::ESP_SVC_CYC,
  parameter int FAN_CYC = esp_pkg::ESP_FAN_CYC,
  parameter int N_DUMB = esp_pkg::ESP_N_DUMB
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ce,
  // Source encoder pins
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  // Freeze, temperature and drive reset pins
  input wire logic freeze_in,
  input wire logic temp_over90,
  input wire logic temp_over100,
  input wire logic drive_reset,
  // Simulated encoder pins
  output logic sim_a,
  output logic sim_b,
  output logic sim_z,
  // Drive side outputs
  output logic fan_full,
  output logic slot_fault_trip,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int SVC_LAST = SVC_CYC * N_DUMB - 1;

  typedef struct packed {
    logic [2:0] fmt;
    logic [15:0] lines;
    logic [2:0] ratio;
    logic [15:0] rev;
    logic [15:0] pos;
    logic [15:0] free_rev;
    logic [15:0] free_pos;
    logic [15:0] idx_rev;
    logic [15:0] idx_pos;
    logic [15:0] snap_rev;
    logic [15:0] snap_pos;
    logic snap_flag;
    logic valid;
    logic hold;
    logic [7:0] fault;
    logic trip;
    logic [1:0] qd_prev;
    logic z_prev;
    logic frz_prev;
    logic frz_pend;
    logic [31:0] svc_cnt;
    logic [31:0] fan_cnt;
    logic fan_full;
    logic [4:0] div_cnt;
    logic sim_step;
    logic sim_dir;
    logic waitreq;
    logic [31:0] rdata;
  } esp_state_t;

  esp_state_t q, d;
  esp_sim_if sif ();

  logic [6:0] pins_s;
  logic a_s;
  logic b_s;
  logic z_s;
  logic frz_s;
  logic hot_s;
  logic over_s;
  logic drst_s;
  logic [1:0] cur_ab;
  logic moved;
  logic fwd;
  logic [3:0] lg_k;
  logic [15:0] step16;
  logic [31:0] turn;
  logic tick;
  logic z_rise;
  logic frz_rise;
  logic [2:0] r_eff;
  logic [4:0] div_mask;
  logic [4:0] div_next;
  logic sim_hit;
  logic wr_go;

  // Floor of log2 of the line count, held to 2..16384
  function automatic logic [3:0] esp_lg(input logic [15:0] n);
    logic [3:0] k;
    k = esp_pkg::ESP_LG_MIN;
    for (int i = 1; i < 16; i++) begin
      if (n[i]) begin
        k = 4'(i);
      end
    end
    if (k > esp_pkg::ESP_LG_MAX) begin
      k = esp_pkg::ESP_LG_MAX;
    end
    return k;
  endfunction

  // All pins cross into the clock domain first
  esp_sync #(
    .W(7)
  ) u_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .din({drive_reset, temp_over100, temp_over90, freeze_in, enc_z, enc_b, enc_a}),
    .dout(pins_s)
  );

  assign a_s = pins_s[0];
  assign b_s = pins_s[1];
  assign z_s = pins_s[2];
  assign frz_s = pins_s[3];
  assign hot_s = pins_s[4];
  assign over_s = pins_s[5];
  assign drst_s = pins_s[6];

  // Quadrature decode; a double jump is dropped as noise
  assign cur_ab = {a_s, b_s};
  assign moved = (cur_ab != q.qd_prev) && (cur_ab != ~q.qd_prev);
  assign fwd = a_s ^ q.qd_prev[0];

  // One count is 1/(4*lines) turn in 1/65536 units
  assign lg_k = esp_lg(q.lines);
  assign step16 = 16'h0001 << (esp_pkg::ESP_LG_MAX - lg_k);
  assign turn = fwd ? {q.rev, q.pos} + {16'h0000, step16}
                    : {q.rev, q.pos} - {16'h0000, step16};

  // Service period and edge events
  assign tick = q.svc_cnt == 32'(SVC_LAST);
  assign z_rise = z_s && !q.z_prev;
  assign frz_rise = frz_s && !q.frz_prev;

  // Ratio divider: one output step per 2^(5-ratio) counts, ratios above 5 taken as 5
  assign r_eff = (q.ratio > esp_pkg::ESP_RATIO_MAX) ? esp_pkg::ESP_RATIO_MAX : q.ratio;
  assign div_mask = 5'h1F >> r_eff;
  assign div_next = fwd ? q.div_cnt + 5'h01 : q.div_cnt - 5'h01;
  assign sim_hit = moved && (fwd ? ((div_next & div_mask) == 5'h00)
                                 : ((q.div_cnt & div_mask) == 5'h00));

  // Write lands on the edge that sees waitrequest low
  assign wr_go = avs_write && !q.waitreq;

  // Next state of the whole block
  always_comb begin
    d = q;
    d.qd_prev = cur_ab;
    d.z_prev = z_s;
    d.frz_prev = frz_s;
    d.sim_step = 1'b0;

    // Main counters; hold freezes them, output keeps running
    if (moved) begin
      d.div_cnt = div_next;
      if (!q.hold) begin
        {d.rev, d.pos} = turn;
      end
      if (sim_hit) begin
        d.sim_step = 1'b1;
        d.sim_dir = fwd;
      end
    end

    // Marker samples the free copies on every rising edge
    if (z_rise) begin
      d.idx_rev = q.free_rev;
      d.idx_pos = q.free_pos;
    end

    // Freeze request waits for the next service tick
    if (frz_rise) begin
      d.frz_pend = 1'b1;
    end

    // Software side of the registers
    if (wr_go) begin
      case (avs_address)
        esp_pkg::ESP_OFS_FMT: d.fmt = avs_writedata[2:0];
        esp_pkg::ESP_OFS_SNAP_FLAG: d.snap_flag = avs_writedata[0];
        esp_pkg::ESP_OFS_HOLD: d.hold = avs_writedata[0];
        esp_pkg::ESP_OFS_LINES: d.lines = avs_writedata[15:0];
        esp_pkg::ESP_OFS_RATIO: d.ratio = avs_writedata[2:0];
        default: d.fmt = q.fmt;
      endcase
    end

    // Service tick: refresh copies, settle freeze; set beats clear
    d.svc_cnt = tick ? 32'h0000_0000 : q.svc_cnt + 32'h0000_0001;
    if (tick) begin
      d.free_rev = q.rev;
      d.free_pos = q.pos;
      d.valid = 1'b1;
      // An edge landing on the tick itself waits one period, else it is lost
      d.frz_pend = frz_rise;
      if (q.frz_pend && !q.snap_flag) begin
        d.snap_rev = q.rev;
        d.snap_pos = q.pos;
        d.snap_flag = 1'b1;
      end
    end

    // Temperature: fan held on for the minimum time after heat
    if (hot_s) begin
      d.fan_cnt = 32'(FAN_CYC);
    end else if (q.fan_cnt != 32'h0000_0000) begin
      d.fan_cnt = q.fan_cnt - 32'h0000_0001;
    end
    d.fan_full = hot_s || (d.fan_cnt != 32'h0000_0000);

    // Drive reset clears the fault; a live overheat wins
    if (drst_s) begin
      d.fault = esp_pkg::ESP_FAULT_NONE;
      d.trip = 1'b0;
    end
    if (over_s) begin
      d.fault = esp_pkg::ESP_FAULT_HOT;
      d.trip = 1'b1;
    end

    // Bus answer one cycle after the request is seen
    d.waitreq = 1'b1;
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata = 32'h0000_0000;
      case (avs_address)
        esp_pkg::ESP_OFS_FMT: d.rdata[2:0] = q.fmt;
        esp_pkg::ESP_OFS_FREE_REV: d.rdata[15:0] = q.free_rev;
        esp_pkg::ESP_OFS_FREE_POS: d.rdata[15:0] = q.free_pos;
        esp_pkg::ESP_OFS_IDX_REV: d.rdata[15:0] = q.idx_rev;
        esp_pkg::ESP_OFS_IDX_POS: d.rdata[15:0] = q.idx_pos;
        esp_pkg::ESP_OFS_SNAP_REV: d.rdata[15:0] = q.snap_rev;
        esp_pkg::ESP_OFS_SNAP_POS: d.rdata[15:0] = q.snap_pos;
        esp_pkg::ESP_OFS_SNAP_FLAG: d.rdata[0] = q.snap_flag;
        esp_pkg::ESP_OFS_VALID: d.rdata[0] = q.valid;
        esp_pkg::ESP_OFS_HOLD: d.rdata[0] = q.hold;
        esp_pkg::ESP_OFS_FAULT: d.rdata[7:0] = q.fault;
        esp_pkg::ESP_OFS_LINES: d.rdata[15:0] = q.lines;
        esp_pkg::ESP_OFS_RATIO: d.rdata[2:0] = q.ratio;
        esp_pkg::ESP_OFS_MAIN_REV: d.rdata[15:0] = q.rev;
        esp_pkg::ESP_OFS_MAIN_POS: d.rdata[15:0] = q.pos;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.fmt <= esp_pkg::ESP_FMT_RST;
      q.lines <= esp_pkg::ESP_LINES_RST;
      q.ratio <= esp_pkg::ESP_RATIO_RST;
      q.waitreq <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // Simulated output stage
  assign sif.step = q.sim_step;
  assign sif.dir = q.sim_dir;
  assign sif.marker = z_s;
  assign sif.fmt = q.fmt;

  esp_sim_out u_sim (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ce(ce),
    .sif(sif),
    .out_a(sim_a),
    .out_b(sim_b),
    .out_z(sim_z)
  );

  // Outputs straight from state
  assign fan_full = q.fan_full;
  assign slot_fault_trip = q.trip;
  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.waitreq;

  default clocking esp_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  sequence s_hot_seen;
    ce && hot_s;
  endsequence
  sequence s_fan_two;
    fan_full ##1 fan_full;
  endsequence
  sequence s_tick_seen;
    ce && tick;
  endsequence

  a_hold_stops_count: assert property (q.hold && ce |=> $stable({q.rev, q.pos}))
    else $error("main counters moved while held");
  a_free_only_tick: assert property (!(tick && ce) |=> $stable({q.free_rev, q.free_pos}))
    else $error("free copy changed off tick");
  a_marker_capture: assert property (ce && z_rise |=> q.idx_rev == $past(q.free_rev))
    else $error("marker capture missed");
  a_freeze_store: assert property (ce && tick && q.frz_pend && !q.snap_flag
    |=> q.snap_flag && q.snap_pos == $past(q.pos))
    else $error("freeze not stored");
  a_freeze_blocked: assert property (q.snap_flag |=> $stable(q.snap_rev))
    else $error("freeze overwritten while flag set");
  a_valid_sticky: assert property (q.valid |=> q.valid)
    else $error("valid flag dropped");
  a_hot_trip_code: assert property (ce && over_s |=> q.fault == 8'h4A && slot_fault_trip)
    else $error("overheat code missing");
  a_drive_reset_clr: assert property (ce && drst_s && !over_s |=> q.fault == 8'h00)
    else $error("fault not cleared");
  a_trip_has_code: assert property (slot_fault_trip |-> q.fault != 8'h00)
    else $error("trip without reason");
  a_fan_forced: assert property (s_hot_seen ##0 ce[*2] |=> s_fan_two)
    else $error("fan not forced");

  // Captures and copies; the fan counter stands in for a long wait
  a_tick_refresh: assert property (s_tick_seen
    |=> q.free_rev == $past(q.rev) && q.free_pos == $past(q.pos) && q.valid)
    else $error("free copy not refreshed on tick");
  a_late_freeze: assert property (s_tick_seen ##0 frz_rise |=> q.frz_pend)
    else $error("freeze edge on tick dropped");
  a_index_kept: assert property (!(ce && z_rise) |=> $stable({q.idx_rev, q.idx_pos}))
    else $error("marker capture changed without marker");
  a_snap_kept: assert property (!(ce && tick) |=> $stable({q.snap_rev, q.snap_pos}))
    else $error("freeze capture changed off tick");
  a_fan_min_time: assert property (q.fan_cnt != 32'h0000_0000 |-> fan_full)
    else $error("fan released before minimum time");
  a_no_fault_idle: assert property (!slot_fault_trip |-> q.fault == 8'h00)
    else $error("reason code without trip");
  a_fault_holds: assert property (!(ce && (drst_s || over_s)) |=> $stable(q.fault))
    else $error("fault reason changed without cause");
endmodule

// ===== tb/esp_enc_model.sv
`timescale 1ns/100ps
// Source encoder with marker, stepped by the bench through its tasks
module esp_enc_model (
  // Clock
  input wire logic clk_sys,
  // Source encoder pins
  output logic enc_a,
  output logic enc_b,
  output logic enc_z
);
  int ph = 0;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_z = 1'b0;
  end
  // Gray steps spaced past the sync latency, else counts are lost
  task automatic step(input int n, input bit fwd);
    repeat (n) begin
      ph = fwd ? (ph + 1) % 4 : (ph + 3) % 4;
      enc_a <= (ph == 1) || (ph == 2);
      enc_b <= (ph >= 2);
      repeat (4) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  // Marker pulse of w cycles, then settle time
  task automatic mark(input int w);
    enc_z <= 1'b1;
    repeat (w) @(posedge clk_sys);
    enc_z <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// ===== tb/esp_top_test.sv
`timescale 1ns/100ps
module esp_top_test;
  localparam int SVC = 50;
  logic clk_sys, resetn, freeze_in, temp_over90, temp_over100, drive_reset;
  logic enc_a, enc_b, enc_z, sim_a, sim_b, sim_z, fan_full, slot_fault_trip;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, pa, pb;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int err_count = 0;
  int total_checks = 0;
  int na = 0, nb = 0, ra = 0, rb = 0, nz = 0, c, d, lg = 10;
  bit [31:0] exp_abs = 0, old;
  bit hold = 0;
  int lines_tab[4] = '{1, 5000, 20000, 1024};

  esp_enc_model u_enc (.clk_sys(clk_sys), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
  esp_top #(.SVC_CYC(SVC), .FAN_CYC(20), .N_DUMB(1)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
    .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
    .freeze_in(freeze_in), .temp_over90(temp_over90), .temp_over100(temp_over100),
    .drive_reset(drive_reset), .sim_a(sim_a), .sim_b(sim_b), .sim_z(sim_z),
    .fan_full(fan_full), .slot_fault_trip(slot_fault_trip),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Edge counters on sim_a and sim_b, high-cycle count on sim_z
  always @(posedge clk_sys) begin
    if (sim_a !== pa) na++;
    if (sim_b !== pb) nb++;
    if (sim_a === 1'b1 && pa === 1'b0) ra++;
    if (sim_b === 1'b1 && pb === 1'b0) rb++;
    if (sim_z === 1'b1) nz++;
    pa = sim_a;
    pb = sim_b;
  end

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= v;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      report_and_stop();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Effective line count as a power of two, clamped 2..16384
  function automatic int lg_of(input int l);
    int g;
    g = 1;
    while ((2 << g) <= l && g < 14) g++;
    return g;
  endfunction

  // Reference model follows every count unless held
  task automatic move(input int n, input bit fwd);
    u_enc.step(n, fwd);
    if (!hold) exp_abs = fwd ? exp_abs + 32'(n << (14 - lg)) : exp_abs - 32'(n << (14 - lg));
  endtask

  task automatic chk_pos(input logic [7:0] ar, input logic [7:0] ap);
    rchk(ar, {16'h0000, exp_abs[31:16]});
    rchk(ap, {16'h0000, exp_abs[15:0]});
  endtask

  // Freeze pulse, then wait past two service ticks
  task automatic freeze;
    freeze_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    freeze_in <= 1'b0;
    repeat (2 * SVC + 10) @(posedge clk_sys);
  endtask

  initial begin
    {resetn, freeze_in, temp_over90, temp_over100, drive_reset} = 5'h00;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    void'($urandom(3));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    // Reset values, access kinds, unmapped place
    rchk(esp_pkg::ESP_OFS_VALID, 32'h0);
    rchk(esp_pkg::ESP_OFS_FMT, 32'(esp_pkg::ESP_FMT_RST));
    rchk(esp_pkg::ESP_OFS_SNAP_FLAG, 32'h0);
    rchk(esp_pkg::ESP_OFS_FAULT, 32'(esp_pkg::ESP_FAULT_NONE));
    rchk(esp_pkg::ESP_OFS_RATIO, 32'(esp_pkg::ESP_RATIO_RST));
    rchk(esp_pkg::ESP_OFS_LINES, 32'(esp_pkg::ESP_LINES_RST));
    bus(1'b1, esp_pkg::ESP_OFS_FMT, 32'hFFFFFFFF);
    rchk(esp_pkg::ESP_OFS_FMT, 32'h7);
    bus(1'b1, 8'h3C, 32'h1);
    rchk(8'h3C, 32'h0);
    bus(1'b1, esp_pkg::ESP_OFS_FREE_POS, 32'h1234);
    rchk(esp_pkg::ESP_OFS_FREE_POS, 32'h0);
    bus(1'b1, esp_pkg::ESP_OFS_FMT, 32'h0);
    // Clamped line counts; ends on a power of two for marker lock
    foreach (lines_tab[i]) begin
      bus(1'b1, esp_pkg::ESP_OFS_LINES, 32'(lines_tab[i]));
      lg = lg_of(lines_tab[i]);
      move(1 + $urandom % 12, 1'b1);
      chk_pos(esp_pkg::ESP_OFS_MAIN_REV, esp_pkg::ESP_OFS_MAIN_POS);
    end
    repeat (3) begin
      move(1 + $urandom % 20, 1'b1);
      move(1 + $urandom % 10, 1'b0);
    end
    chk_pos(esp_pkg::ESP_OFS_MAIN_REV, esp_pkg::ESP_OFS_MAIN_POS);
    // Hold stops main counters, release resumes them
    bus(1'b1, esp_pkg::ESP_OFS_HOLD, 32'h1);
    hold = 1'b1;
    move(6, 1'b1);
    chk_pos(esp_pkg::ESP_OFS_MAIN_REV, esp_pkg::ESP_OFS_MAIN_POS);
    rchk(esp_pkg::ESP_OFS_HOLD, 32'h1);
    bus(1'b1, esp_pkg::ESP_OFS_HOLD, 32'h0);
    hold = 1'b0;
    move(6, 1'b0);
    chk_pos(esp_pkg::ESP_OFS_MAIN_REV, esp_pkg::ESP_OFS_MAIN_POS);
    // Service tick refreshes copies and sets valid
    repeat (2 * SVC + 10) @(posedge clk_sys);
    rchk(esp_pkg::ESP_OFS_VALID, 32'h1);
    chk_pos(esp_pkg::ESP_OFS_FREE_REV, esp_pkg::ESP_OFS_FREE_POS);
    u_enc.mark(4);
    chk_pos(esp_pkg::ESP_OFS_IDX_REV, esp_pkg::ESP_OFS_IDX_POS);
    chk_pos(esp_pkg::ESP_OFS_FREE_REV, esp_pkg::ESP_OFS_FREE_POS);
    // Freeze capture, blocked while flag set, then re-armed
    freeze();
    chk_pos(esp_pkg::ESP_OFS_SNAP_REV, esp_pkg::ESP_OFS_SNAP_POS);
    rchk(esp_pkg::ESP_OFS_SNAP_FLAG, 32'h1);
    old = exp_abs;
    move(5, 1'b1);
    freeze();
    rchk(esp_pkg::ESP_OFS_SNAP_POS, {16'h0000, old[15:0]});
    rchk(esp_pkg::ESP_OFS_IDX_POS, {16'h0000, old[15:0]});
    chk_pos(esp_pkg::ESP_OFS_FREE_REV, esp_pkg::ESP_OFS_FREE_POS);
    bus(1'b1, esp_pkg::ESP_OFS_SNAP_FLAG, 32'h0);
    rchk(esp_pkg::ESP_OFS_SNAP_FLAG, 32'h0);
    freeze();
    chk_pos(esp_pkg::ESP_OFS_SNAP_REV, esp_pkg::ESP_OFS_SNAP_POS);
    // Output formats at ratio 1:1
    bus(1'b1, esp_pkg::ESP_OFS_RATIO, 32'h5);
    c = na + nb;
    move(8, 1'b1);
    chk(32'(na + nb - c), 32'd8);
    bus(1'b1, esp_pkg::ESP_OFS_FMT, 32'h1);
    // A format switch may flip a pin once; let it be counted first
    repeat (2) @(posedge clk_sys);
    c = na;
    move(8, 1'b1);
    chk(32'(na - c), 32'd8);
    chk(sim_b, 32'h1);
    move(8, 1'b0);
    chk(sim_b, 32'h0);
    bus(1'b1, esp_pkg::ESP_OFS_FMT, 32'h2);
    repeat (2) @(posedge clk_sys);
    c = ra;
    d = rb;
    move(8, 1'b1);
    move(8, 1'b0);
    chk(32'(ra - c), 32'd8);
    chk(32'(rb - d), 32'd8);
    // Every ratio code; 32 counts divide evenly at any divider phase
    bus(1'b1, esp_pkg::ESP_OFS_FMT, 32'h1);
    for (int r = 0; r < 8; r++) begin
      bus(1'b1, esp_pkg::ESP_OFS_RATIO, 32'(r));
      c = na;
      move(32, 1'b1);
      chk(32'(na - c), 32'(32 >> (5 - (r > 5 ? 5 : r))));
    end
    // Lock formats, re-armed through format 0 each time
    for (int f = 3; f < 8; f++) begin
      bus(1'b1, esp_pkg::ESP_OFS_FMT, 32'h0);
      bus(1'b1, esp_pkg::ESP_OFS_FMT, 32'(f));
      move(3, 1'b1);
      c = nz;
      u_enc.mark(3 + 2 * (f % 2));
      chk(sim_a, 32'h1);
      if (f == 3) chk(sim_b, 32'h1);
      chk(32'(nz - c), 32'(3 + 2 * (f % 2)));
    end
    // Fan hold after the hot signal drops
    temp_over90 <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(fan_full, 32'h1);
    temp_over90 <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(fan_full, 32'h1);
    repeat (40) @(posedge clk_sys);
    chk(fan_full, 32'h0);
    // Overheat trip, then drive reset clears it
    temp_over100 <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rchk(esp_pkg::ESP_OFS_FAULT, 32'(esp_pkg::ESP_FAULT_HOT));
    chk(slot_fault_trip, 32'h1);
    temp_over100 <= 1'b0;
    drive_reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    drive_reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rchk(esp_pkg::ESP_OFS_FAULT, 32'h0);
    chk(slot_fault_trip, 32'h0);
    report_and_stop();
  end
endmodule
